// *** rtl/hbc_host.sv ***
// Host controller driving three half bridges through PWM, enable and mode pins
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`include "hbc_map.svh"
module hbc_host #(
   parameter int unsigned WAIT_CYC = `HBC_WAIT_CYC
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET,
   input wire logic [3:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   input wire logic I_FAULT_N,
   input wire logic I_OVERHEAT_WARNING_N,
   output hbc_pkg::hbc_drive_t O_DRIVE,
   output logic O_LOAD_REDUCE
);
   import hbc_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] meta_ff;
   logic [1:0] sync_ff;
   hbc_status_t pins;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         meta_ff <= 2'h3;
         sync_ff <= 2'h3;
      end else begin
         meta_ff <= {I_FAULT_N, I_OVERHEAT_WARNING_N};
         sync_ff <= meta_ff;
      end
   end
   assign pins = sync_ff;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] ctrl_ff;
   logic [15:0] per_ff;
   logic [15:0] duty_ff [3];
   logic [15:0] rdata_ff;
   logic fault_seen_ff;
   logic [2:0] en_hold_ff;
   wire wr_ctrl = I_WR && (I_ADDR == `HBC_ADDR_CTRL);
   wire wr_per = I_WR && (I_ADDR == `HBC_ADDR_PER);
   wire [2:0] wr_duty = {I_WR && (I_ADDR == `HBC_ADDR_DUTYC),
                         I_WR && (I_ADDR == `HBC_ADDR_DUTYB),
                         I_WR && (I_ADDR == `HBC_ADDR_DUTY)};
   wire clr_req = wr_ctrl && I_WDATA[`HBC_CTRL_CLR_BIT];
   wire fault_now = !pins.fault_n;

   // ----------------------------------------
   // Recovery sequencer
   // ----------------------------------------
   hbc_state_t state_ff;
   hbc_state_t nxt_state;
   logic [31:0] wait_ff;
   wire wait_done = (wait_ff >= WAIT_CYC);
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         HBC_RUN: begin
            if (fault_now) begin
               nxt_state = HBC_HOLD;
            end
         end
         HBC_HOLD: begin
            if (!fault_now) begin
               nxt_state = HBC_RUN;
            end else if (clr_req) begin
               nxt_state = HBC_WAIT;
            end
         end
         HBC_WAIT: begin
            if (wait_done) begin
               nxt_state = HBC_PULSE;
            end
         end
         HBC_PULSE: begin
            nxt_state = HBC_RUN;
         end
         default: begin
            nxt_state = HBC_RUN;
         end
      endcase
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         state_ff <= HBC_RUN;
         wait_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == HBC_RUN) begin
            wait_ff <= 32'h0;
         end else if (!wait_done) begin
            wait_ff <= wait_ff + 32'h1;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         ctrl_ff <= `HBC_CTRL_RESET;
         per_ff <= `HBC_PER_RESET;
         fault_seen_ff <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= {4'h0, I_WDATA[3:0]};
         end
         if (wr_per) begin
            per_ff <= I_WDATA;
         end
         if (fault_now) begin
            fault_seen_ff <= 1'b1;
         end else if (clr_req) begin
            fault_seen_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // PWM generation, one counter shared
   // ----------------------------------------
   logic [15:0] cnt_ff;
   logic [2:0] pwm_ff;
   logic [15:0] duty_lim [3];
   wire [15:0] low_min = 16'(`HBC_MIN_LOW_CYC);
   wire [15:0] duty_cap = (per_ff > low_min) ? (per_ff - low_min) : 16'h0;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         cnt_ff <= 16'h0;
      end else if (cnt_ff + 16'h1 >= per_ff) begin
         cnt_ff <= 16'h0;
      end else begin
         cnt_ff <= cnt_ff + 16'h1;
      end
   end

   for (genvar p = 0; p < 3; p++) begin : g_ph
      // Cap duty so the low side is on every period, halve while warned
      wire [15:0] base = (duty_ff[p] > duty_cap) ? duty_cap : duty_ff[p];
      assign duty_lim[p] = pins.overheat_warning_n ? base : {1'b0, base[15:1]};
      always_ff @(posedge I_CORE_CLK) begin
         if (I_RESET) begin
            duty_ff[p] <= `HBC_DUTY_RESET;
            pwm_ff[p] <= 1'b0;
            en_hold_ff[p] <= 1'b0;
         end else begin
            if (wr_duty[p]) begin
               duty_ff[p] <= I_WDATA;
            end
            // PWM toggles each period while the limited duty is nonzero, ending any constant level hold
            pwm_ff[p] <= (cnt_ff < duty_lim[p]);
            en_hold_ff[p] <= ctrl_ff[`HBC_CTRL_EN_LSB + p] && (state_ff != HBC_PULSE);
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic [2:0] en_out_ff;
   logic mode_ff;
   logic reduce_ff;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         en_out_ff <= 3'h0;
         mode_ff <= 1'b0;
         reduce_ff <= 1'b0;
      end else begin
         // Low enable forces off; pulse gives each phase enabled in the control register a rising edge
         en_out_ff <= en_hold_ff;
         mode_ff <= ctrl_ff[`HBC_CTRL_MODE_BIT];
         reduce_ff <= !pins.overheat_warning_n;
      end
   end
   assign O_DRIVE.pwm = pwm_ff;
   assign O_DRIVE.enable_n = en_out_ff;
   assign O_DRIVE.mode_select_first = mode_ff;
   assign O_LOAD_REDUCE = reduce_ff;

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   wire [15:0] stat_word = {10'h0, fault_seen_ff, (state_ff != HBC_RUN),
                            pins.fault_n, pins.overheat_warning_n, 2'h0};
   wire [15:0] rd_mux = (I_ADDR == `HBC_ADDR_CTRL) ? {8'h0, ctrl_ff} :
                        (I_ADDR == `HBC_ADDR_PER) ? per_ff :
                        (I_ADDR == `HBC_ADDR_DUTY) ? duty_ff[0] :
                        (I_ADDR == `HBC_ADDR_DUTYB) ? duty_ff[1] :
                        (I_ADDR == `HBC_ADDR_DUTYC) ? duty_ff[2] :
                        (I_ADDR == `HBC_ADDR_STAT) ? stat_word : 16'h0;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         rdata_ff <= 16'h0;
      end else if (I_RD) begin
         rdata_ff <= rd_mux;
      end else begin
         rdata_ff <= 16'h0;
      end
   end
   assign O_RDATA = rdata_ff;
endmodule

// *** rtl/hbc_map.svh ***
// Offsets, fields, reset values and timing counts of the half-bridge host controller
// Notes on behaviour
// - Controller watches warning and reduces load current when it asserts.
// - Controller waits at least one second after shutdown before reset.
// - Controller keeps the low side on a minimum time every PWM cycle.
// - Mode-select input picks cycle limiting or latching overcurrent shutdown.
// - Constant PWM through cycle overcurrent leaves phase off; toggling restores it.
// - Latching mode shuts down; all three enables are pulsed to restore; controller pulses only phases enabled in the control register.
// - Cycle shutdown clears by its enable edge; latched needs all three edges.
// - Mode-select driven to 0 selects cycle-by-cycle limiting.
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HBC_ADDR_CTRL 4'h0
`define HBC_ADDR_DUTY 4'h1
`define HBC_ADDR_PER 4'h2
`define HBC_ADDR_STAT 4'h3
`define HBC_ADDR_DUTYB 4'h4
`define HBC_ADDR_DUTYC 4'h5

// ----------------------------------------
// Control fields
// ----------------------------------------
`define HBC_CTRL_EN_LSB 0
`define HBC_CTRL_MODE_BIT 3
`define HBC_CTRL_CLR_BIT 4
`define HBC_CTRL_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define HBC_CLK_NS 100
`define HBC_MIN_LOW_NS 50
`define HBC_MIN_LOW_CYC ((`HBC_MIN_LOW_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_WAIT_S 1
`define HBC_WAIT_CYC (`HBC_WAIT_S * 1000000000 / `HBC_CLK_NS)
`define HBC_PER_RESET 16'h0064
`define HBC_DUTY_RESET 16'h0032

`endif

// *** rtl/hbc_pkg.sv ***
// Types of the half-bridge host controller
package hbc_pkg;
   typedef struct packed {
      logic [2:0] pwm;
      logic [2:0] enable_n;
      logic mode_select_first;
   } hbc_drive_t;

   typedef struct packed {
      logic fault_n;
      logic overheat_warning_n;
   } hbc_status_t;

   typedef enum {
      HBC_RUN,
      HBC_HOLD,
      HBC_WAIT,
      HBC_PULSE
   } hbc_state_t;
endpackage

// *** verif/hbc_host_sva.sv ***
// Checker of the half-bridge host controller ports
`timescale 1ns/10ps
module hbc_sva #(parameter int unsigned WAIT_CYC = 20) (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET,
   input wire logic [3:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [15:0] O_RDATA,
   input wire logic I_FAULT_N,
   input wire logic I_OVERHEAT_WARNING_N,
   input wire hbc_pkg::hbc_drive_t O_DRIVE,
   input wire logic O_LOAD_REDUCE
);
   import hbc_pkg::*;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);
   logic [31:0] flt_ff;
   logic [31:0] hi_ff;
   wire ctrl_wr = I_WR && I_ADDR == 4'h0;
   always_ff @(posedge I_CORE_CLK) begin
      flt_ff <= I_FAULT_N ? 32'h0 : flt_ff + 32'h1;
      hi_ff <= O_DRIVE.pwm[0] ? hi_ff + 32'h1 : 32'h0;
   end
   sequence s_pulse;
      $past(O_DRIVE.enable_n) == 3'h7 && O_DRIVE.enable_n == 3'h0 && !I_FAULT_N;
   endsequence
   sequence s_ctrl;
      ctrl_wr ##1 !ctrl_wr;
   endsequence
   a_warn_reduce: assert property (!I_OVERHEAT_WARNING_N [*4] |-> O_LOAD_REDUCE)
      else $error("reduce missing");
   a_warn_release: assert property (I_OVERHEAT_WARNING_N [*4] |-> !O_LOAD_REDUCE)
      else $error("reduce stuck");
   a_reset_quiet: assert property ($fell(I_RESET) |-> O_DRIVE == 7'h00)
      else $error("drive after reset");
   a_low_each: assert property (hi_ff < 32'h0000ffff)
      else $error("pwm never low");
   a_wait_long: assert property (s_pulse |-> flt_ff > WAIT_CYC)
      else $error("recovery too early");
   a_pulse_one: assert property (s_pulse |=> O_DRIVE.enable_n == 3'h7)
      else $error("enable pulse length");
   a_mode_follow: assert property (s_ctrl |=> O_DRIVE.mode_select_first == $past(I_WDATA[3], 2))
      else $error("mode not applied");
   a_en_follow: assert property (I_FAULT_N [*4] ##0 s_ctrl ##0 I_FAULT_N
      |=> ##1 O_DRIVE.enable_n == $past(I_WDATA[2:0], 3)) else $error("enable not applied");
endmodule
bind hbc_host hbc_sva #(.WAIT_CYC(WAIT_CYC)) u_sva (.I_CORE_CLK, .I_RESET, .I_ADDR, .I_WDATA,
   .I_WR, .I_RD, .O_RDATA, .I_FAULT_N, .I_OVERHEAT_WARNING_N, .O_DRIVE, .O_LOAD_REDUCE);

// *** verif/hbc_dev_model.sv ***
// Behavioural model of the three half-bridge power stage
`timescale 1ns/10ps
module hbc_dev (
   input wire logic i_clk,
   input wire hbc_pkg::hbc_drive_t i_drive,
   input wire logic [2:0] i_oc,
   input wire logic i_warm,
   output logic o_fault_n,
   output logic o_warn_n,
   output logic [2:0] o_on
);
   import hbc_pkg::*;
   logic [2:0] en_ff = 3'h0;
   logic [2:0] seen_ff = 3'h0;
   logic [2:0] cbc_ff = 3'h0;
   logic latch_ff = 1'b0;
   logic [2:0] lim_ff = 3'h0;
   logic [2:0] pwm_ff = 3'h0;
   wire [2:0] en = i_drive.enable_n;
   wire [2:0] rise = en & ~en_ff;
   wire [2:0] prise = i_drive.pwm & ~pwm_ff;
   wire [2:0] run = en & ~cbc_ff & ~lim_ff & {3{~latch_ff}};
   assign o_on = run;
   assign o_fault_n = (latch_ff | (|cbc_ff)) ? 1'b0 : 1'b1;
   assign o_warn_n = i_warm ? 1'b0 : 1'b1;
   always @(posedge i_clk) begin
      en_ff <= en;
      pwm_ff <= i_drive.pwm;
      lim_ff <= (lim_ff & ~prise) | (i_oc & {3{~i_drive.mode_select_first}});
      cbc_ff <= (cbc_ff & ~rise) | (i_oc & {3{~i_drive.mode_select_first}});
      seen_ff <= latch_ff ? seen_ff | rise : 3'h0;
      if (|i_oc && i_drive.mode_select_first) latch_ff <= 1'b1;
      else if (&(seen_ff | rise)) latch_ff <= 1'b0;
   end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench of the half-bridge host controller
`timescale 1ns/10ps
module tb_top;
   import hbc_pkg::*;
   localparam int unsigned WC = 20;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, warm = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0, rdata, d;
   logic [2:0] oc = 3'h0, on;
   logic flt_n, warn_n, reduce;
   hbc_drive_t drive;
   logic [15:0] expq[$];
   logic [31:0] seed = 32'ha318;
   int errors = 0, checks = 0, n;
   hbc_host #(.WAIT_CYC(WC)) DUT (.I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_FAULT_N(flt_n),
      .I_OVERHEAT_WARNING_N(warn_n), .O_DRIVE(drive), .O_LOAD_REDUCE(reduce));
   hbc_dev u_dev (.i_clk(clk), .i_drive(drive), .i_oc(oc), .i_warm(warm),
      .o_fault_n(flt_n), .o_warn_n(warn_n), .o_on(on));
   initial forever #50 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= !w;
      if (!w) expq.push_back(v);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic duty(input logic [15:0] v, input logic [15:0] e);
      bus(1'b1, 4'h1, v);
      repeat (40) @(posedge clk);
      n = 0;
      repeat (16) begin
         @(posedge clk);
         n += drive.pwm[0];
      end
      chk(16'(n), e);
   endtask
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd_q) chk(rdata, expq.pop_front());
   end
   initial begin
      #2000000;
      errors++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 16'h0000);
      bus(1'b0, 4'h2, 16'h0064);
      bus(1'b0, 4'hf, 16'h0000);
      bus(1'b0, 4'h3, 16'h000c);
      bus(1'b1, 4'h2, 16'h0010);
      bus(1'b1, 4'h0, 16'h0017);
      bus(1'b0, 4'h3, 16'h000c);
      seed = xs(seed);
      d = seed[15:0] % 16'h0010;
      duty(d, d);
      duty(16'h0010, 16'h000f);
      chk({13'h0, on}, 16'h0007);
      warm <= 1'b1;
      repeat (8) @(posedge clk);
      chk({15'h0, reduce}, 16'h0001);
      bus(1'b0, 4'h3, 16'h0008);
      warm <= 1'b0;
      repeat (8) @(posedge clk);
      bus(1'b0, 4'h3, 16'h000c);
      bus(1'b1, 4'h0, 16'h000f);
      repeat (2) @(posedge clk);
      oc <= 3'h1;
      @(posedge clk);
      oc <= 3'h0;
      repeat (8) @(posedge clk);
      chk({13'h0, on}, 16'h0000);
      bus(1'b0, 4'h3, 16'h0034);
      bus(1'b1, 4'h0, 16'h001f);
      repeat (WC + 10) @(posedge clk);
      bus(1'b0, 4'h3, 16'h002c);
      chk({13'h0, on}, 16'h0007);
      complete_run();
   end
endmodule
